// ==== hw/user_config_bank.sv ====
// Purpose: user strings, identifier and configuration command bank
// Assumes: outer serial engine frames each command as start/bytes/end
// Notes:   read bytes appear two cycles after each rdReq
`timescale 1ns/1ps
`default_nettype none
module user_config_bank (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// command framing
	input  wire logic        txStart,
	input  wire logic        txWrite,
	input  wire logic [7:0]  txCode,
	input  wire logic        txEnd,
	input  wire logic        wrValid,
	input  wire logic [7:0]  wrData,
	input  wire logic        rdReq,
	output logic             rdValid,
	output logic      [7:0]  rdData,
	// memory commands and error flag
	input  wire logic        storeCmd,
	input  wire logic        restoreCmd,
	input  wire logic        errClear,
	output logic             budgetError,
	output logic      [7:0]  budgetUsed,
	// strap and power good level
	input  wire logic [4:0]  strapFeatures,
	input  wire logic        powerGoodLevel,
	// configuration outputs
	output logic      [7:0]  senseBlankCycles,
	output logic      [1:0]  senseRange,
	output logic             minDutyEnable,
	output logic      [1:0]  minDutySelect,
	output logic             power_good_output_o,
	output logic             power_good_output_oe,
	output logic             externalTempEnable,
	output logic      [2:0]  phasePosition,
	output logic      [4:0]  railId,
	output logic      [3:0]  railDeviceCount
);
	localparam int SC = cfg_bank_pkg::STRING_COUNT;
	localparam int PB = cfg_bank_pkg::POS_BITS;

	typedef struct packed {
		cfg_bank_pkg::tx_state_t   txState;
		logic [7:0]                code;
		logic [2:0]                strIdx;
		logic                      isString;
		logic                      refused;
		logic                      countSkipped;
		logic [PB-1:0]             pos;
		logic [SC-1:0][PB-1:0]     len;
		logic [SC-1:0][PB-1:0]     storedLen;
		logic [7:0]                used;
		logic                      userWritten;
		logic                      strapTaken;
		logic [4:0]                strap;
		logic                      stageValid;
		logic                      stageFromMem;
		logic [7:0]                stageByte;
		logic                      rdValid;
		logic [7:0]                rdData;
		logic                      budgetError;
		logic [7:0]                blankCycles;
		logic [1:0]                senseRange;
		logic                      minDutyEnable;
		logic [1:0]                minDutySelect;
		logic                      pgOut;
		logic                      pgOe;
		logic                      extTemp;
		logic [2:0]                phase;
		logic [4:0]                railId;
		logic [3:0]                railCount;
	} bank_state_t;

	bank_state_t state;
	bank_state_t next_state;

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [7:0]  senseVal;
	logic [7:0]  featureVal;
	logic [15:0] railVal;
	logic [31:0] groupVal;
	logic [7:0]  memRdData;
	logic        regWrite;
	logic [1:0]  regIdx;
	logic        memWrite;
	logic [cfg_bank_pkg::MEM_ADDR_BITS-1:0] memWrAddr;
	logic [cfg_bank_pkg::MEM_ADDR_BITS-1:0] memRdAddr;

	cfg_field_reg #(
		.WIDTH     (8),
		.RESET_VAL (cfg_bank_pkg::SENSE_RESET),
		.WR_MASK   (cfg_bank_pkg::SENSE_MASK)
	) u_sense (
		.core_clk (core_clk),
		.rst      (rst),
		.wrEn     (regWrite && state.code == cfg_bank_pkg::CMD_SENSE_SETUP),
		.wrIdx    (regIdx),
		.wrByte   (wrData),
		.value    (senseVal)
	);

	cfg_field_reg #(
		.WIDTH     (8),
		.RESET_VAL (cfg_bank_pkg::FEATURE_RESET),
		.WR_MASK   (cfg_bank_pkg::FEATURE_MASK)
	) u_feature (
		.core_clk (core_clk),
		.rst      (rst),
		.wrEn     (regWrite && state.code == cfg_bank_pkg::CMD_FEATURE),
		.wrIdx    (regIdx),
		.wrByte   (wrData),
		.value    (featureVal)
	);

	cfg_field_reg #(
		.WIDTH     (16),
		.RESET_VAL (cfg_bank_pkg::RAIL_RESET),
		.WR_MASK   (cfg_bank_pkg::RAIL_MASK)
	) u_rail (
		.core_clk (core_clk),
		.rst      (rst),
		.wrEn     (regWrite && state.code == cfg_bank_pkg::CMD_RAIL_ADDRESS),
		.wrIdx    (regIdx),
		.wrByte   (wrData),
		.value    (railVal)
	);

	cfg_field_reg #(
		.WIDTH     (32),
		.RESET_VAL (cfg_bank_pkg::GROUP_RESET),
		.WR_MASK   (cfg_bank_pkg::GROUP_MASK)
	) u_group (
		.core_clk (core_clk),
		.rst      (rst),
		.wrEn     (regWrite && state.code == cfg_bank_pkg::CMD_FAULT_GROUP),
		.wrIdx    (regIdx),
		.wrByte   (wrData),
		.value    (groupVal)
	);

	string_mem u_strings (
		.core_clk (core_clk),
		.wrEn     (memWrite),
		.wrAddr   (memWrAddr),
		.wrData   (wrData),
		.rdAddr   (memRdAddr),
		.rdData   (memRdData)
	);

	// ------------------------------------------------------------
	// command decode helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] string_slot(input logic [7:0] code);
		unique case (code)
			cfg_bank_pkg::CMD_MANUFACTURER: string_slot = 4'h8;
			cfg_bank_pkg::CMD_MODEL:        string_slot = 4'h9;
			cfg_bank_pkg::CMD_REVISION:     string_slot = 4'ha;
			cfg_bank_pkg::CMD_LOCATION:     string_slot = 4'hb;
			cfg_bank_pkg::CMD_DATE:         string_slot = 4'hc;
			cfg_bank_pkg::CMD_SERIAL:       string_slot = 4'hd;
			cfg_bank_pkg::CMD_USER_DATA:    string_slot = 4'he;
			default:                        string_slot = 4'h0;
		endcase
	endfunction

	// block commands carry a leading count byte; byte and word ones do not
	function automatic logic is_block(input logic [7:0] code);
		logic [3:0] s;
		s = string_slot(code);
		is_block = code == cfg_bank_pkg::CMD_FAULT_GROUP
			|| code == cfg_bank_pkg::CMD_CHIP_ID
			|| s[3];
	endfunction

	logic [7:0] sumStored;
	logic [7:0] lenByte;
	logic [3:0] slot;
	logic [7:0] regByte;
	logic [7:0] writeCost;
	logic [4:0] featureEff;

	always_comb
	begin
		sumStored = cfg_bank_pkg::OVERHEAD_ALL;
		for (int i = 0; i < SC; i++)
			sumStored = sumStored + 8'(state.len[i]);
	end

	assign slot      = string_slot(txCode);
	assign lenByte   = 8'(state.len[state.strIdx]);
	// cost of the write so far plus the byte now offered
	assign writeCost = 8'(state.pos) + cfg_bank_pkg::OVERHEAD_ONE
		+ cfg_bank_pkg::OVERHEAD_ONE;

	assign regWrite  = state.txState == cfg_bank_pkg::ST_WRITE && wrValid
		&& !state.isString && (state.countSkipped || !is_block(state.code));
	assign regIdx    = state.pos[1:0];
	assign memWrite  = state.txState == cfg_bank_pkg::ST_WRITE && wrValid
		&& state.isString && state.countSkipped && !state.refused
		&& state.used + writeCost <= cfg_bank_pkg::BUDGET_LIMIT;
	assign memWrAddr = {state.strIdx, state.pos};
	// the count byte sits at pos 0, so character k is read at pos k+1
	assign memRdAddr = {state.strIdx, 7'(state.pos - 7'h01)};

	// a host write to the feature register replaces the strap
	assign featureEff = state.userWritten ? featureVal[4:0] : state.strap;

	always_comb
	begin
		regByte = 8'h00;
		unique case (state.code)
			cfg_bank_pkg::CMD_SENSE_SETUP:  regByte = senseVal;
			cfg_bank_pkg::CMD_FEATURE:      regByte = featureVal;
			cfg_bank_pkg::CMD_RAIL_ADDRESS: regByte = railVal[state.pos[0]*8 +: 8];
			cfg_bank_pkg::CMD_FAULT_GROUP:
				regByte = state.pos == '0 ? 8'h04
					: groupVal[7'(state.pos - 7'h01)*8 +: 8];
			cfg_bank_pkg::CMD_CHIP_ID:
				regByte = state.pos == '0 ? 8'h04
					: cfg_bank_pkg::CHIP_ID_VALUE[7'(state.pos - 7'h01)*8 +: 8];
			default:                        regByte = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.stageValid = 1'b0;
		next_state.rdValid = state.stageValid;
		next_state.rdData = state.stageFromMem ? memRdData : state.stageByte;

		// strap is caught on the first edge after reset release
		if (!state.strapTaken)
		begin
			next_state.strapTaken = 1'b1;
			next_state.strap = strapFeatures;
		end

		unique case (state.txState)
			cfg_bank_pkg::ST_IDLE:
			begin
				if (txStart)
				begin
					next_state.txState = txWrite ? cfg_bank_pkg::ST_WRITE
						: cfg_bank_pkg::ST_READ;
					next_state.code = txCode;
					next_state.strIdx = slot[2:0];
					next_state.isString = slot[3];
					next_state.refused = 1'b0;
					next_state.countSkipped = !is_block(txCode);
					next_state.pos = '0;
					// writing the identifier is refused at once
					if (txWrite && txCode == cfg_bank_pkg::CMD_CHIP_ID)
						next_state.refused = 1'b1;
				end
			end
			cfg_bank_pkg::ST_WRITE:
			begin
				if (wrValid && !state.countSkipped)
					next_state.countSkipped = 1'b1;
				else if (wrValid && state.isString && !state.refused)
				begin
					if (memWrite)
						next_state.pos = 7'(state.pos + 7'h01);
					else
						next_state.refused = 1'b1;
				end
				else if (wrValid && !state.refused)
					next_state.pos = 7'(state.pos + 7'h01);
				if (txEnd)
				begin
					next_state.txState = cfg_bank_pkg::ST_IDLE;
					// the last byte may share the cycle with txEnd
					if (state.isString && !next_state.refused)
					begin
						next_state.len[state.strIdx] = next_state.pos;
						// every committed string write is charged in full
						next_state.used = state.used + 8'(next_state.pos)
							+ cfg_bank_pkg::OVERHEAD_ONE;
					end
					if (state.code == cfg_bank_pkg::CMD_FEATURE
						&& next_state.pos != '0)
						next_state.userWritten = 1'b1;
				end
			end
			cfg_bank_pkg::ST_READ:
			begin
				if (rdReq)
				begin
					next_state.stageValid = 1'b1;
					next_state.pos = 7'(state.pos + 7'h01);
					if (state.isString)
					begin
						next_state.stageFromMem = state.pos != '0
							&& state.pos <= state.len[state.strIdx];
						next_state.stageByte = state.pos == '0 ? lenByte
							: 8'h00;
					end
					else
					begin
						next_state.stageFromMem = 1'b0;
						next_state.stageByte = regByte;
					end
				end
				if (txEnd)
					next_state.txState = cfg_bank_pkg::ST_IDLE;
			end
		endcase

		// store snapshots lengths; restore reloads them and the budget
		if (storeCmd)
			next_state.storedLen = state.len;
		if (restoreCmd)
		begin
			next_state.len = state.storedLen;
			next_state.used = cfg_bank_pkg::OVERHEAD_ALL;
			for (int i = 0; i < SC; i++)
				next_state.used = next_state.used + 8'(state.storedLen[i]);
		end
		if (storeCmd && !restoreCmd)
			next_state.used = next_state.txState == state.txState
				? sumStored : next_state.used;

		// a refusal in the same cycle as the clear still leaves the flag set
		if (errClear)
			next_state.budgetError = 1'b0;
		if (state.txState == cfg_bank_pkg::ST_WRITE && wrValid
			&& (state.refused ? 1'b0 : (state.isString && state.countSkipped
			&& !memWrite)))
			next_state.budgetError = 1'b1;
		if (state.txState == cfg_bank_pkg::ST_IDLE && txStart && txWrite
			&& txCode == cfg_bank_pkg::CMD_CHIP_ID)
			next_state.budgetError = 1'b1;

		// ------------------------------------------------------------
		// registered configuration outputs
		// ------------------------------------------------------------
		unique case (senseVal[cfg_bank_pkg::SENSE_BLANK_LSB +: 2])
			2'h0: next_state.blankCycles = cfg_bank_pkg::BLANK_0_CYC;
			2'h1: next_state.blankCycles = cfg_bank_pkg::BLANK_1_CYC;
			2'h2: next_state.blankCycles = cfg_bank_pkg::BLANK_2_CYC;
			2'h3: next_state.blankCycles = cfg_bank_pkg::BLANK_3_CYC;
		endcase
		next_state.senseRange =
			senseVal[cfg_bank_pkg::SENSE_RANGE_LSB +: 2];
		next_state.minDutyEnable =
			featureEff[cfg_bank_pkg::MIN_DUTY_EN_BIT];
		// the duty setting is only meaningful while its enable is set
		next_state.minDutySelect =
			featureEff[cfg_bank_pkg::MIN_DUTY_EN_BIT]
			? featureEff[cfg_bank_pkg::MIN_DUTY_LSB +: 2] : 2'h0;
		if (featureEff[cfg_bank_pkg::PG_PUSHPULL_BIT])
		begin
			next_state.pgOut = powerGoodLevel;
			next_state.pgOe = 1'b1;
		end
		else
		begin
			next_state.pgOut = 1'b0;
			next_state.pgOe = !powerGoodLevel;
		end
		next_state.extTemp = featureEff[cfg_bank_pkg::EXT_TEMP_BIT];
		next_state.phase = railVal[cfg_bank_pkg::PHASE_LSB +: 3];
		next_state.railId = railVal[cfg_bank_pkg::RAIL_ID_LSB +: 5];
		next_state.railCount =
			{1'b0, railVal[cfg_bank_pkg::RAIL_COUNT_LSB +: 3]} + 4'h1;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= '0;
			state.txState <= cfg_bank_pkg::ST_IDLE;
			state.used <= cfg_bank_pkg::OVERHEAD_ALL;
			state.blankCycles <= cfg_bank_pkg::BLANK_1_CYC;
			state.senseRange <= 2'h1;
			state.railCount <= 4'h1;
		end
		else
			state <= next_state;
	end

	assign rdValid              = state.rdValid;
	assign rdData               = state.rdData;
	assign budgetError          = state.budgetError;
	assign budgetUsed           = state.used;
	assign senseBlankCycles     = state.blankCycles;
	assign senseRange           = state.senseRange;
	assign minDutyEnable        = state.minDutyEnable;
	assign minDutySelect        = state.minDutySelect;
	assign power_good_output_o  = state.pgOut;
	assign power_good_output_oe = state.pgOe;
	assign externalTempEnable   = state.extTemp;
	assign phasePosition        = state.phase;
	assign railId               = state.railId;
	assign railDeviceCount      = state.railCount;
endmodule // user_config_bank
`default_nettype wire

// ==== include/cfg_bank_pkg.sv ====
// Purpose: shared constants for the user configuration command bank
// Assumes: byte-wide command framing delivered by an outer serial engine
// Notes:   command codes double as register offsets
package cfg_bank_pkg;

	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_MANUFACTURER = 8'h99;
	localparam logic [7:0] CMD_MODEL        = 8'h9a;
	localparam logic [7:0] CMD_REVISION     = 8'h9b;
	localparam logic [7:0] CMD_LOCATION     = 8'h9c;
	localparam logic [7:0] CMD_DATE         = 8'h9d;
	localparam logic [7:0] CMD_SERIAL       = 8'h9e;
	localparam logic [7:0] CMD_FAULT_GROUP  = 8'ha8;
	localparam logic [7:0] CMD_CHIP_ID      = 8'had;
	localparam logic [7:0] CMD_USER_DATA    = 8'hb0;
	localparam logic [7:0] CMD_SENSE_SETUP  = 8'hd0;
	localparam logic [7:0] CMD_FEATURE      = 8'hd1;
	localparam logic [7:0] CMD_RAIL_ADDRESS = 8'hd3;

	// ------------------------------------------------------------
	// string budget
	// ------------------------------------------------------------
	localparam int         STRING_COUNT  = 7;
	localparam logic [7:0] BUDGET_LIMIT  = 8'h80;
	localparam logic [7:0] OVERHEAD_ONE  = 8'h01;
	localparam logic [7:0] OVERHEAD_ALL  = 8'h07;
	localparam int         POS_BITS      = 7;
	localparam int         MEM_ADDR_BITS = 10;

	// ------------------------------------------------------------
	// register layouts and reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  SENSE_RESET   = 8'h25;
	localparam logic [7:0]  SENSE_MASK    = 8'h0f;
	localparam logic [7:0]  FEATURE_RESET = 8'h00;
	localparam logic [7:0]  FEATURE_MASK  = 8'h1f;
	localparam logic [15:0] RAIL_RESET    = 16'h0000;
	localparam logic [15:0] RAIL_MASK     = 16'hff07;
	localparam logic [31:0] GROUP_RESET   = 32'h00000000;
	localparam logic [31:0] GROUP_MASK    = 32'hffffffff;
	// arbitrary neutral identifier value
	localparam logic [31:0] CHIP_ID_VALUE = 32'h0a5a0001;

	localparam int SENSE_BLANK_LSB = 2;
	localparam int SENSE_RANGE_LSB = 0;
	localparam int MIN_DUTY_LSB    = 3;
	localparam int MIN_DUTY_EN_BIT = 2;
	localparam int PG_PUSHPULL_BIT = 1;
	localparam int EXT_TEMP_BIT    = 0;
	localparam int PHASE_LSB       = 13;
	localparam int RAIL_ID_LSB     = 8;
	localparam int RAIL_COUNT_LSB  = 0;

	// ------------------------------------------------------------
	// blanking times
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int BLANK_0_NS    = 192;
	localparam int BLANK_1_NS    = 256;
	localparam int BLANK_2_NS    = 412;
	localparam int BLANK_3_NS    = 640;
	localparam logic [7:0] BLANK_0_CYC =
		8'((BLANK_0_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [7:0] BLANK_1_CYC =
		8'((BLANK_1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [7:0] BLANK_2_CYC =
		8'((BLANK_2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [7:0] BLANK_3_CYC =
		8'((BLANK_3_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} tx_state_t;

endpackage

// ==== hw/cfg_field_reg.sv ====
// Purpose: byte-writable configuration register with a writable-bit mask
// Assumes: byte 0 is the least significant byte, as sent on the link
// Notes:   bits outside the mask keep their reset value
`timescale 1ns/1ps
`default_nettype none
module cfg_field_reg #(
	parameter int             WIDTH     = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0,
	parameter logic [WIDTH-1:0] WR_MASK   = '1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// byte write
	input  wire logic             wrEn,
	input  wire logic [1:0]       wrIdx,
	input  wire logic [7:0]       wrByte,
	// contents
	output logic      [WIDTH-1:0] value
);
	typedef struct packed {
		logic [WIDTH-1:0] value;
	} reg_state_t;

	reg_state_t state;
	reg_state_t next_state;

	always_comb
	begin
		next_state = state;
		for (int b = 0; b < WIDTH / 8; b++)
		begin
			if (wrEn && wrIdx == 2'(b))
			begin
				next_state.value[b*8 +: 8] =
					(wrByte & WR_MASK[b*8 +: 8])
					| (RESET_VAL[b*8 +: 8] & ~WR_MASK[b*8 +: 8]);
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state <= '{value: RESET_VAL};
		else
			state <= next_state;
	end

	assign value = state.value;
endmodule // cfg_field_reg
`default_nettype wire

// ==== hw/string_mem.sv ====
// Purpose: character storage for the seven user strings
// Assumes: one write and one read per cycle
// Notes:   read data is registered, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module string_mem (
	// clock
	input  wire logic                                core_clk,
	// write port
	input  wire logic                                wrEn,
	input  wire logic [cfg_bank_pkg::MEM_ADDR_BITS-1:0] wrAddr,
	input  wire logic [7:0]                          wrData,
	// read port
	input  wire logic [cfg_bank_pkg::MEM_ADDR_BITS-1:0] rdAddr,
	output logic      [7:0]                          rdData
);
	logic [7:0] cells [0:(1 << cfg_bank_pkg::MEM_ADDR_BITS)-1];

	// no reset on the array: lengths gate what can be read back
	always_ff @(posedge core_clk)
	begin
		if (wrEn)
			cells[wrAddr] <= wrData;
		rdData <= cells[rdAddr];
	end
endmodule // string_mem
`default_nettype wire

// ==== bench/cfg_bank_assertions.sv ====
// Purpose: port assertions for the user configuration bank
// Assumes: one clock, reset asynchronous and high
// Notes:   bound to every bank instance by name
`timescale 1ns/1ps
`default_nettype none
module cfg_bank_chk (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// link and budget
	input wire logic       rdReq,
	input wire logic       rdValid,
	input wire logic       storeCmd,
	input wire logic       restoreCmd,
	input wire logic       errClear,
	input wire logic       budgetError,
	input wire logic [7:0] budgetUsed,
	// configuration
	input wire logic [7:0] senseBlankCycles,
	input wire logic       minDutyEnable,
	input wire logic [1:0] minDutySelect,
	input wire logic       power_good_output_o,
	input wire logic       power_good_output_oe,
	input wire logic [3:0] railDeviceCount
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	rd_latency_a: assert property (rdReq |-> ##2 rdValid)
		else $error("read answer late");
	rd_cause_a: assert property (rdValid |-> $past(rdReq, 2))
		else $error("read answer without request");
	blank_code_a: assert property (senseBlankCycles inside
		{8'd39, 8'd52, 8'd83, 8'd128}) else $error("bad blanking");
	duty_gate_a: assert property (!minDutyEnable |-> !minDutySelect)
		else $error("duty select while disabled");
	pg_drive_a: assert property (power_good_output_o |->
		power_good_output_oe) else $error("pin high undriven");
	rail_count_a: assert property (railDeviceCount inside
		{[4'h1:4'h8]}) else $error("bad device count");
	budget_cap_a: assert property (budgetUsed <= 8'h80 &&
		budgetUsed >= 8'h07) else $error("budget out of range");
	// store and restore act at the next edge; the cycle after one is skipped as well
	budget_grow_a: assert property (!storeCmd && !restoreCmd &&
		!$past(storeCmd) && !$past(restoreCmd) |=>
		budgetUsed >= $past(budgetUsed)) else $error("budget fell");
	err_sticky_a: assert property (budgetError && !errClear
		|=> budgetError) else $error("error flag dropped");
	cover property (rdValid);
	cover property ($rose(budgetError));
	cover property (minDutyEnable && power_good_output_oe);
endmodule // cfg_bank_chk
bind user_config_bank cfg_bank_chk chk (.*);
`default_nettype wire

// ==== bench/host_model.sv ====
// Purpose: command host driving the bank framing
// Assumes: inputs change at the falling edge
// Notes:   idle data lines show inverted last value after a write
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// clock
	input wire logic        core_clk,
	// framing
	output logic            txStart,
	output logic            txWrite,
	output logic      [7:0] txCode,
	output logic            txEnd,
	output logic            wrValid,
	output logic      [7:0] wrData,
	output logic            rdReq,
	input wire logic        rdValid,
	input wire logic  [7:0] rdData,
	// memory commands and error clear
	output logic            storeCmd,
	output logic            restoreCmd,
	output logic            errClear
);
	initial
	begin
		{txStart, txWrite, txEnd, wrValid, rdReq} = 5'h00;
		{storeCmd, restoreCmd, errClear} = 3'h0;
		{txCode, wrData} = 16'h0000;
	end
	task automatic wr(input logic [7:0] c, input logic [7:0] b[$]);
		@(negedge core_clk);
		txStart = 1'b1;
		txWrite = 1'b1;
		txCode = c;
		foreach (b[i])
		begin
			@(negedge core_clk);
			txStart = 1'b0;
			wrValid = 1'b1;
			wrData = b[i];
			txEnd = (i == b.size() - 1);
		end
		@(negedge core_clk);
		{txStart, wrValid, txEnd} = 3'h0;
		wrData = ~wrData;
		txCode = ~txCode;
	endtask
	task automatic rd(input logic [7:0] c, input int n,
		output logic [7:0] q[$]);
		q = {};
		@(negedge core_clk);
		txStart = 1'b1;
		txWrite = 1'b0;
		txCode = c;
		for (int i = 0; i < n + 3; i++)
		begin
			@(negedge core_clk);
			txStart = 1'b0;
			if (rdValid === 1'b1)
				q.push_back(rdData);
			rdReq = (i < n);
		end
		txEnd = 1'b1;
		@(negedge core_clk);
		txEnd = 1'b0;
	endtask
	task automatic pulse(input logic s, r, e);
		@(negedge core_clk);
		{storeCmd, restoreCmd, errClear} = {s, r, e};
		@(negedge core_clk);
		{storeCmd, restoreCmd, errClear} = 3'h0;
	endtask
endmodule // host_model
`default_nettype wire

// ==== bench/user_config_bank_tb.sv ====
// Purpose: self-checking bench for the user configuration bank
// Assumes: outputs settle one cycle after the register
// Notes:   strap asks for external temperature
`timescale 1ns/1ps
`default_nettype none
module user_config_bank_tb;
	typedef struct packed {
		logic [7:0]  code;
		logic [15:0] wd;
		logic [15:0] rd;
	} row_t;
	localparam row_t ROWS [5] = '{'{8'hd0, 16'h000e, 16'h002e},
		'{8'hd0, 16'h00f3, 16'h0023}, '{8'hd3, 16'hffff, 16'hff07},
		'{8'hd3, 16'h5a12, 16'h5a02}, '{8'hd1, 16'h00ff, 16'h001f}};
	localparam logic [7:0] BL [4] = '{8'd39, 8'd52, 8'd83, 8'd128};
	logic       core_clk = 1'b0;
	logic       rst = 1'b1;
	logic [4:0] strapFeatures = 5'h01;
	logic       powerGoodLevel = 1'b1;
	wire logic  txStart, txWrite, txEnd, wrValid, rdReq, rdValid;
	wire logic  storeCmd, restoreCmd, errClear, budgetError;
	wire logic  [7:0] txCode, wrData, rdData, budgetUsed, senseBlankCycles;
	wire logic  [1:0] senseRange, minDutySelect;
	wire logic  minDutyEnable, externalTempEnable;
	wire logic  power_good_output_o, power_good_output_oe;
	wire logic  [2:0] phasePosition;
	wire logic  [4:0] railId;
	wire logic  [3:0] railDeviceCount;
	logic [7:0] q[$], b[$];
	int         errors = 0, compares = 0, cyc = 0, n;
	user_config_bank dut (.*);
	host_model host (.*);
	always #2.5 core_clk = ~core_clk;
	task automatic ck(input string s, input logic [39:0] e, g);
		compares++;
		if (e !== g)
		begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wt(input int k);
		repeat (k) @(negedge core_clk);
	endtask
	task automatic end_sim;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			errors++;
			end_sim();
		end
	end
	initial
	begin
		wt(20);
		ck("blank at reset", 8'd52, senseBlankCycles);
		ck("count at reset", 4'h1, railDeviceCount);
		rst = 1'b0;
		wt(3);
		ck("strap temp", 1'b1, externalTempEnable);
		host.rd(8'hd0, 1, q);
		ck("sense reset", cfg_bank_pkg::SENSE_RESET, q[0]);
		host.rd(8'hd3, 2, q);
		ck("rail reset", 16'h0000, {q[1], q[0]});
		host.rd(8'ha8, 5, q);
		ck("group reset", 40'h04, {q[4], q[3], q[2], q[1], q[0]});
		host.rd(8'h99, 1, q);
		ck("string empty", 8'h00, q[0]);
		$display("test reset done");
		foreach (ROWS[i])
		begin
			n = (ROWS[i].code == 8'hd3) ? 2 : 1;
			b = {ROWS[i].wd[7:0], ROWS[i].wd[15:8]};
			b = b[0:n-1];
			host.wr(ROWS[i].code, b);
			host.rd(ROWS[i].code, n, q);
			if (n == 1)
				q.push_back(8'h00);
			ck("readback", ROWS[i].rd, {q[1], q[0]});
		end
		wt(3);
		ck("fields", 16'h5a3f, {phasePosition, railId, railDeviceCount,
			senseRange, minDutySelect});
		ck("feature", 4'hf, {minDutyEnable, power_good_output_oe,
			power_good_output_o, externalTempEnable});
		host.wr(8'hd1, {8'h18});
		wt(3);
		ck("duty off", 5'h00, {minDutySelect, minDutyEnable,
			externalTempEnable, power_good_output_oe});
		powerGoodLevel = 1'b0;
		wt(3);
		ck("open drain", 2'h2, {power_good_output_oe, power_good_output_o});
		for (int k = 0; k < 4; k++)
		begin
			host.wr(8'hd0, {8'(k * 5)});
			wt(3);
			ck("blank range", {BL[k], 2'(k)}, {senseBlankCycles, senseRange});
		end
		$display("test fields done");
		host.wr(8'had, {8'h04, 8'h01, 8'h02, 8'h03, 8'h04});
		wt(2);
		ck("id write err", 1'b1, budgetError);
		host.rd(8'had, 5, q);
		ck("id value", {cfg_bank_pkg::CHIP_ID_VALUE, 8'h04},
			{q[4], q[3], q[2], q[1], q[0]});
		host.pulse(1'b0, 1'b0, 1'b1);
		wt(2);
		ck("err clear", 1'b0, budgetError);
		host.wr(8'h99, {8'h02, 8'h61, 8'h62});
		wt(2);
		ck("used one", 8'd10, budgetUsed);
		host.rd(8'h99, 3, q);
		ck("string", 24'h026162, {q[0], q[1], q[2]});
		host.wr(8'h99, {8'h02, 8'h61, 8'h62});
		wt(2);
		ck("used twice", 8'd13, budgetUsed);
		host.pulse(1'b0, 1'b1, 1'b0);
		host.wr(8'h99, {8'h02, 8'h61, 8'h62});
		host.pulse(1'b1, 1'b0, 1'b0);
		host.pulse(1'b0, 1'b1, 1'b0);
		wt(2);
		ck("used cleared", 8'd9, budgetUsed);
		b = {8'd125};
		repeat (125) b.push_back(8'h78);
		host.wr(8'hb0, b);
		wt(2);
		ck("over budget", 1'b1, budgetError);
		host.rd(8'hb0, 1, q);
		ck("length kept", 8'h00, q[0]);
		$display("test budget done");
		end_sim();
	end
endmodule // user_config_bank_tb
`default_nettype wire
